// ### shared/adc_seq_regs.svh
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ****************************************************************
// control word layout on the parallel bus
// ****************************************************************
`define CTL_RANGE_BIT 0
`define CTL_SEQ_BIT 1
`define CTL_MASK_SELECT_BIT_BIT 2
`define CTL_CODING_BIT 3
`define CTL_PM_LO 4
`define CTL_PM_HI 5
`define CTL_MODE_LO 6
`define CTL_MODE_HI 7
`define CTL_ADDR_LO 8
`define CTL_ADDR_HI 10
`define MASK_LO 0
`define MASK_HI 7

// ****************************************************************
// reset values
// ****************************************************************
`define CTL_RANGE_RST 1'h0
`define CTL_CODING_RST 1'h0
`define CTL_PM_RST 2'h0
`define CTL_MODE_RST 2'h0
`define CTL_ADDR_RST 3'h0
`define MASK_RST 8'h00

// ****************************************************************
// conversion timing and coding
// ****************************************************************
`define CONV_PERIODS 4'hd
`define LAST_DECIDE 4'hb
`define SAR_START 12'h800
`define SIGN_FLIP 12'h800
`define PAIR_KEEP 8'h55

`endif

// ### shared/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_MASK,
    SEQ_CONSEC
  } seq_mode_t;

endpackage

// ### core/edge_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// two-stage synchroniser with edge detect
// ****************************************************************
module edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule

`default_nettype wire

// ### core/adc_channel_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_regs.svh"

// Summary of operation
// - conversion needs thirteen full clock periods
// - short conversions are abandoned, no result
// - eight-bit mask captured on strobe rising
// - mask written only after select write
// - mask bit n selects channel n
// - each start advances to next selected, ascending
// - sequence runs until a non-hold write
// - pair-mode sequences convert normal polarity only
// - sequencer off: channel from address bits
// - hold write updates fields, keeps sequence
// - both bits set: channels zero to address
// - start falling edge samples and advances
// - result straight binary or twos complement
// - twelve-bit code, one step per lsb
module adc_channel_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CH_N = 8,
  parameter int RES_W = 12,
  parameter int BUS_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic conversion_clock,
  input wire logic convert_start_n,
  input wire logic write_strobe_n,
  input wire logic [BUS_W-1:0] bus_data,
  input wire logic comparator_in,
  output logic [$clog2(CH_N)-1:0] channel_select_r,
  output logic [RES_W-1:0] dac_trial_r,
  output logic hold_r,
  output logic busy_r,
  output logic [RES_W-1:0] result_r,
  output logic result_valid_r,
  output logic conv_abort_r,
  output logic range_sel_r,
  output logic [1:0] power_mode_r,
  output logic [1:0] input_config_r
);

  localparam int CH_W = $clog2(CH_N);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic clkc_rise;
  logic cs_fall;
  logic wr_rise;
  logic comp_q;
  logic [BUS_W-1:0] bus_q;

  edge_sync #(.WIDTH(1)) u_clkc (
    .clk_sys(clk_sys), .rst_n(rst_n), .pin_in(conversion_clock),
    .level(), .rise(clkc_rise), .fall()
  );

  edge_sync #(.WIDTH(1)) u_cs (
    .clk_sys(clk_sys), .rst_n(rst_n), .pin_in(convert_start_n),
    .level(), .rise(), .fall(cs_fall)
  );

  edge_sync #(.WIDTH(1)) u_wr (
    .clk_sys(clk_sys), .rst_n(rst_n), .pin_in(write_strobe_n),
    .level(), .rise(wr_rise), .fall()
  );

  edge_sync #(.WIDTH(1)) u_comp (
    .clk_sys(clk_sys), .rst_n(rst_n), .pin_in(comparator_in),
    .level(comp_q), .rise(), .fall()
  );

  edge_sync #(.WIDTH(BUS_W)) u_bus (
    .clk_sys(clk_sys), .rst_n(rst_n), .pin_in(bus_data),
    .level(bus_q), .rise(), .fall()
  );

  // ****************************************************************
  // write steering
  // ****************************************************************
  logic shadow_pend_r;
  logic ctl_wr;
  logic mask_wr;
  logic [1:0] bus_seqsel;

  assign ctl_wr = wr_rise & ~shadow_pend_r;
  assign mask_wr = wr_rise & shadow_pend_r;
  assign bus_seqsel = {bus_q[`CTL_SEQ_BIT], bus_q[`CTL_MASK_SELECT_BIT_BIT]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shadow_pend_r <= 1'b0;
    end else if (ctl_wr) begin
      shadow_pend_r <= (bus_seqsel == 2'h1);
    end else if (mask_wr) begin
      shadow_pend_r <= 1'b0;
    end
  end

  // ****************************************************************
  // control fields
  // ****************************************************************
  logic coding_r;
  logic [CH_W-1:0] addr_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      range_sel_r <= `CTL_RANGE_RST;
      coding_r <= `CTL_CODING_RST;
      power_mode_r <= `CTL_PM_RST;
      input_config_r <= `CTL_MODE_RST;
      addr_r <= `CTL_ADDR_RST;
    end else if (ctl_wr) begin
      range_sel_r <= bus_q[`CTL_RANGE_BIT];
      coding_r <= bus_q[`CTL_CODING_BIT];
      power_mode_r <= bus_q[`CTL_PM_HI:`CTL_PM_LO];
      input_config_r <= bus_q[`CTL_MODE_HI:`CTL_MODE_LO];
      addr_r <= bus_q[`CTL_ADDR_HI:`CTL_ADDR_LO];
    end
  end

  // ****************************************************************
  // channel mask
  // ****************************************************************
  logic [CH_N-1:0] mask_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `MASK_RST;
    end else if (mask_wr) begin
      mask_r <= bus_q[`MASK_HI:`MASK_LO];
    end
  end

  // ****************************************************************
  // sequence mode and position
  // ****************************************************************
  seq_mode_t seq_mode_r;
  logic [CH_W:0] ptr_r;
  logic seq_restart;

  assign seq_restart = mask_wr | (ctl_wr & (bus_seqsel != 2'h2));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seq_mode_r <= SEQ_OFF;
    end else if (mask_wr) begin
      seq_mode_r <= SEQ_MASK;
    end else if (ctl_wr) begin
      case (bus_seqsel)
        2'h2: seq_mode_r <= seq_mode_r;
        2'h3: seq_mode_r <= SEQ_CONSEC;
        default: seq_mode_r <= SEQ_OFF;
      endcase
    end
  end

  // ****************************************************************
  // next channel search
  // ****************************************************************
  logic pair_mode;
  logic [CH_N-1:0] base_mask;
  logic [CH_N-1:0] eff_mask;
  logic [CH_W-1:0] next_ch;
  logic [CH_W-1:0] low_ch;
  logic next_found;
  logic any_found;
  logic [CH_W-1:0] start_ch;

  assign pair_mode = input_config_r[0] ^ input_config_r[1];

  always_comb begin
    base_mask = '0;
    for (int i = 0; i < CH_N; i++) begin
      if (seq_mode_r == SEQ_CONSEC) begin
        base_mask[i] = (CH_W'(i) <= addr_r);
      end else begin
        base_mask[i] = mask_r[i];
      end
    end
    eff_mask = pair_mode ? (base_mask & `PAIR_KEEP) : base_mask;
  end

  always_comb begin
    next_ch = '0;
    low_ch = '0;
    next_found = 1'b0;
    any_found = 1'b0;
    for (int i = CH_N - 1; i >= 0; i--) begin
      if (eff_mask[i]) begin
        low_ch = CH_W'(i);
        any_found = 1'b1;
        if ((CH_W + 1)'(i) >= ptr_r) begin
          next_ch = CH_W'(i);
          next_found = 1'b1;
        end
      end
    end
    if (!next_found) begin
      next_ch = low_ch;
    end
  end

  always_comb begin
    if (seq_mode_r != SEQ_OFF && any_found) begin
      start_ch = next_ch;
    end else begin
      start_ch = addr_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= '0;
    end else if (seq_restart) begin
      ptr_r <= '0;
    end else if (cs_fall && seq_mode_r != SEQ_OFF) begin
      ptr_r <= {1'b0, next_ch} + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      channel_select_r <= '0;
    end else if (cs_fall) begin
      channel_select_r <= start_ch;
    end
  end

  // ****************************************************************
  // conversion engine
  // ****************************************************************
  conv_state_t state_r;
  logic [3:0] per_cnt_r;
  logic [RES_W-1:0] trial_nxt;
  logic [3:0] bit_idx;

  assign bit_idx = 4'(RES_W - 1) - per_cnt_r;

  always_comb begin
    trial_nxt = dac_trial_r;
    if (!comp_q && per_cnt_r <= `LAST_DECIDE) begin
      trial_nxt[bit_idx] = 1'b0;
    end
    if (per_cnt_r < `LAST_DECIDE) begin
      trial_nxt[bit_idx - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CONV_IDLE;
      per_cnt_r <= '0;
      dac_trial_r <= '0;
    end else if (cs_fall) begin
      state_r <= CONV_RUN;
      per_cnt_r <= '0;
      dac_trial_r <= `SAR_START;
    end else if (state_r == CONV_RUN && (ctl_wr || mask_wr)) begin
      state_r <= CONV_IDLE;
    end else if (state_r == CONV_RUN && clkc_rise) begin
      per_cnt_r <= per_cnt_r + 4'h1;
      if (per_cnt_r <= `LAST_DECIDE) begin
        dac_trial_r <= trial_nxt;
      end
      if (per_cnt_r + 4'h1 == `CONV_PERIODS) begin
        state_r <= CONV_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= '0;
      result_valid_r <= 1'b0;
    end else if (state_r == CONV_RUN && clkc_rise && !cs_fall &&
                 !ctl_wr && !mask_wr &&
                 per_cnt_r + 4'h1 == `CONV_PERIODS) begin
      result_r <= coding_r ? (dac_trial_r ^ `SIGN_FLIP) : dac_trial_r;
      result_valid_r <= 1'b1;
    end else begin
      result_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_abort_r <= 1'b0;
    end else begin
      conv_abort_r <= (state_r == CONV_RUN) &&
                      (cs_fall || ctl_wr || mask_wr);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      busy_r <= (state_r == CONV_RUN);
      hold_r <= cs_fall || (state_r == CONV_RUN && busy_r);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  result_after_full_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    result_valid_r |-> $past(per_cnt_r) == `CONV_PERIODS - 4'h1)
    else $error("result without thirteen periods");

  abort_no_result_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cs_fall && state_r == CONV_RUN) |=> conv_abort_r && !result_valid_r)
    else $error("aborted conversion gave result");

  mask_capture_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mask_wr |=> mask_r == $past(bus_q[`MASK_HI:`MASK_LO]))
    else $error("mask not captured");

  mask_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctl_wr |=> $stable(mask_r))
    else $error("mask changed on control write");

  seq_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ctl_wr && bus_seqsel == 2'h2 && !cs_fall) |=>
      $stable(seq_mode_r) && $stable(ptr_r))
    else $error("hold write disturbed sequence");

  seq_stop_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ctl_wr && bus_seqsel[1] == 1'b0) |=> seq_mode_r == SEQ_OFF)
    else $error("sequence not stopped");

  pair_skip_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cs_fall && seq_mode_r != SEQ_OFF && pair_mode && any_found) |=>
      !channel_select_r[0])
    else $error("inverse pair converted");

  fixed_chan_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cs_fall && seq_mode_r == SEQ_OFF) |=>
      channel_select_r == $past(addr_r))
    else $error("wrong fixed channel");

  coding_sel_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    result_valid_r |->
      (result_r ^ dac_trial_r) == ($past(coding_r) ? `SIGN_FLIP : '0))
    else $error("wrong output coding");

  start_run_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_fall |=> state_r == CONV_RUN && per_cnt_r == 4'h0 ##1 busy_r)
    else $error("start edge did not begin conversion");

  ascend_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cs_fall && seq_mode_r != SEQ_OFF && next_found && !seq_restart) |=>
      {1'b0, channel_select_r} >= $past(ptr_r) &&
      ptr_r == {1'b0, channel_select_r} + 1'b1)
    else $error("sequence not ascending");

  wrap_low_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cs_fall && seq_mode_r != SEQ_OFF && any_found && !next_found) |=>
      channel_select_r == $past(low_ch))
    else $error("no wrap to lowest channel");

endmodule

`default_nettype wire

// ### tb/adc_input_model.sv
`timescale 1ns/1ns
`default_nettype none

// ******************************
// analog inputs behind the comparator
// ******************************
module adc_input_model #(
  parameter logic [11:0] BASE = 12'h1a3,
  parameter logic [11:0] STEP = 12'h1f5
) (
  input wire logic [2:0] channel,
  input wire logic [11:0] trial,
  output logic decide
);
  logic [11:0] level;

  // each channel sits at a fixed dc code
  assign level = 12'(BASE + channel * STEP);
  assign decide = (level >= trial);
endmodule

`default_nettype wire

// ### tb/adc_channel_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(12'(g), 12'(e))

module adc_channel_sequencer_test;
  localparam logic [11:0] BASE = 12'h1a3;
  localparam logic [11:0] STEP = 12'h1f5;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic conversion_clock = 1'b0;
  logic convert_start_n = 1'b1;
  logic write_strobe_n = 1'b0;
  logic [11:0] bus_data = 12'h000;
  logic comparator_in;
  logic [2:0] channel_select_r;
  logic [11:0] dac_trial_r;
  logic [11:0] result_r;
  logic hold_r;
  logic busy_r;
  logic result_valid_r;
  logic conv_abort_r;
  logic range_sel_r;
  logic [1:0] power_mode_r;
  logic [1:0] input_config_r;
  logic [11:0] last_res = 12'h000;
  logic [2:0] got_ch;
  logic got_hold;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_valid = 0;
  int n_abort = 0;
  int v0;
  int a0;

  // ******************************
  // design and analog side
  // ******************************
  adc_channel_sequencer i_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .conversion_clock(conversion_clock),
    .convert_start_n(convert_start_n),
    .write_strobe_n(write_strobe_n),
    .bus_data(bus_data),
    .comparator_in(comparator_in),
    .channel_select_r(channel_select_r),
    .dac_trial_r(dac_trial_r),
    .hold_r(hold_r),
    .busy_r(busy_r),
    .result_r(result_r),
    .result_valid_r(result_valid_r),
    .conv_abort_r(conv_abort_r),
    .range_sel_r(range_sel_r),
    .power_mode_r(power_mode_r),
    .input_config_r(input_config_r)
  );

  adc_input_model #(.BASE(BASE), .STEP(STEP)) i_model (
    .channel(channel_select_r),
    .trial(dac_trial_r),
    .decide(comparator_in)
  );

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ******************************
  // helpers
  // ******************************
  function automatic logic [11:0] lvl(input logic [2:0] c);
    return 12'(BASE + c * STEP);
  endfunction

  function automatic logic [11:0] ctl(input logic sq, input logic sh,
    input logic cod, input logic [1:0] cfg, input logic [2:0] ad);
    return {1'b0, ad, cfg, 2'b00, cod, sh, sq, 1'b0};
  endfunction

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] w);
    @(posedge clk_sys);
    bus_data <= w;
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic conv(input int n);
    @(posedge clk_sys);
    convert_start_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    got_ch = channel_select_r;
    got_hold = hold_r;
    convert_start_n <= 1'b1;
    repeat (n) begin
      conversion_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      conversion_clock <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  task automatic conv_chk(input logic [2:0] ch, input logic cod);
    v0 = n_valid;
    conv(13);
    repeat (4) @(posedge clk_sys);
    `CHK(got_ch, ch);
    `CHK(n_valid - v0, 1);
    `CHK(last_res, lvl(ch) ^ {cod, 11'h000});
    `CHK(dac_trial_r, lvl(ch));
    `CHK(got_hold, 1);
    `CHK(hold_r, 0);
  endtask

  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ******************************
  // result watch and timeout
  // ******************************
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (result_valid_r === 1'b1) begin
      n_valid <= n_valid + 1;
      last_res <= result_r;
    end
    if (conv_abort_r === 1'b1) begin
      n_abort <= n_abort + 1;
    end
    if (cyc == 12000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ******************************
  // tests
  // ******************************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(channel_select_r, 0);
    `CHK(busy_r, 0);
    wr(12'h031);
    `CHK(range_sel_r, 1);
    `CHK(power_mode_r, 3);
    wr(ctl(0, 0, 0, 2'h0, 3'h5));
    conv_chk(3'h5, 1'b0);
    wr(ctl(0, 0, 1, 2'h0, 3'h2));
    conv_chk(3'h2, 1'b1);
    test_end("fixed");
    wr(ctl(0, 0, 0, 2'h0, 3'h3));
    a0 = n_abort;
    v0 = n_valid;
    conv(12);
    repeat (8) @(posedge clk_sys);
    `CHK(n_valid - v0, 0);
    conv_chk(3'h3, 1'b0);
    `CHK(n_abort - a0, 1);
    test_end("abort");
    wr(ctl(0, 1, 0, 2'h0, 3'h0));
    wr(12'h026);
    conv_chk(3'h1, 1'b0);
    conv_chk(3'h2, 1'b0);
    conv_chk(3'h5, 1'b0);
    conv_chk(3'h1, 1'b0);
    wr(ctl(1, 0, 1, 2'h0, 3'h0));
    conv_chk(3'h2, 1'b1);
    wr(ctl(0, 0, 0, 2'h0, 3'h7));
    conv_chk(3'h7, 1'b0);
    test_end("mask");
    wr(ctl(1, 1, 0, 2'h0, 3'h2));
    for (int i = 0; i < 4; i++) begin
      conv_chk(3'(i % 3), 1'b0);
    end
    test_end("consecutive");
    for (int k = 1; k < 3; k++) begin
      wr(ctl(0, 1, 0, 2'(k), 3'h0));
      `CHK(input_config_r, k);
      wr(12'h03c);
      conv_chk(3'h2, 1'b0);
      conv_chk(3'h4, 1'b0);
      conv_chk(3'h2, 1'b0);
    end
    test_end("pairs");
    wrap_up();
  end
endmodule

`undef CHK
`default_nettype wire
